// file: hw/sfc_pkg.sv
// sfc_pkg: offsets, field positions, codes and carriers shared by
// the socket force and control register block.
// assumes a 32-bit AXI4-Lite register bus with byte addresses.
package sfc_pkg;
    // register byte offsets
    localparam logic [7:0] SFC_FORCE_OFS = 8'h0C;
    localparam logic [7:0] SFC_CTRL_OFS = 8'h10;
    // force register field positions
    localparam int SFC_F_RETEST = 14;
    localparam int SFC_F_YY = 13;
    localparam int SFC_F_XX = 12;
    localparam int SFC_F_THREE = 11;
    localparam int SFC_F_FIVE = 10;
    localparam int SFC_F_INVALID = 9;
    localparam int SFC_F_LOSS = 8;
    localparam int SFC_F_UNREC = 7;
    localparam int SFC_F_CARDBUS = 5;
    localparam int SFC_F_SIXTEEN = 4;
    localparam int SFC_F_POWER = 3;
    localparam int SFC_F_DET_TWO = 2;
    localparam int SFC_F_DET_ONE = 1;
    localparam int SFC_F_STATUS = 0;
    // control register field positions and layout
    localparam int SFC_C_POLICY = 7;
    localparam int SFC_C_VCC = 4;
    localparam int SFC_C_VPP = 0;
    localparam logic [31:0] SFC_CTRL_MASK = 32'h0000_00F7;
    localparam logic SFC_POLICY_RESET = 1'h0;
    localparam logic [2:0] SFC_VOLT_RESET = 3'h0;
    // voltage request codes
    localparam logic [2:0] SFC_V_OFF = 3'h0;
    localparam logic [2:0] SFC_V_12 = 3'h1;
    localparam logic [2:0] SFC_V_5 = 3'h2;
    localparam logic [2:0] SFC_V_33 = 3'h3;
    localparam logic [2:0] SFC_V_XX = 3'h4;
    localparam logic [2:0] SFC_V_YY = 3'h5;
    // idle clocks before the card clock may be stopped
    localparam logic [3:0] SFC_IDLE_CLOCKS = 4'h8;
    // bus responses
    localparam logic [1:0] SFC_OKAY = 2'h0;
    localparam logic [1:0] SFC_SLVERR = 2'h2;
    // present-state bits that the force register loads
    typedef struct packed {
        logic yy;
        logic xx;
        logic three;
        logic five;
        logic loss;
        logic unrec;
        logic cardbus;
        logic sixteen;
    } sfc_ps_t;
    // socket event bits that the force register loads
    typedef struct packed {
        logic power;
        logic det_two;
        logic det_one;
        logic status;
    } sfc_evt_t;
endpackage

// file: hw/sfc_top.sv
// sfc_top: socket force-event and socket control registers on an
// AXI4-Lite slave, with voltage screening and clock-stop decision.
// assumes the present-state and event registers live outside and
// take the PS_* and EVT_* load strobes; all inputs but RST synchronous to CLK.
`timescale 1ns/1ps
module sfc_top import sfc_pkg::*; #(
    parameter int ADDR_W = 8
) (
    input wire logic CLK, // 100 MHz clock
    input wire logic RST, // global reset, async
    input wire logic CE, // clock enable
    input wire logic HOST_BUS_RESET, // host bus reset, sync
    input wire logic WAKE_EN, // wake signalling enabled
    input wire logic CARDBUS_IN, // cardbus card inserted
    input wire logic [3:0] CARD_CAP, // card accepts yy,xx,3v3,5v
    input wire logic CARD_IDLE, // card interface idle
    input wire logic HOST_STOP_REQ, // host asks clock stop
    input wire logic [ADDR_W-1:0] AWADDR, // write address
    input wire logic AWVALID, // write address valid
    output logic AWREADY, // write address ready
    input wire logic [31:0] WDATA, // write data
    input wire logic [3:0] WSTRB, // write byte strobes
    input wire logic WVALID, // write data valid
    output logic WREADY, // write data ready
    output logic [1:0] BRESP, // write response
    output logic BVALID, // write response valid
    input wire logic BREADY, // write response ready
    input wire logic [ADDR_W-1:0] ARADDR, // read address
    input wire logic ARVALID, // read address valid
    output logic ARREADY, // read address ready
    output logic [31:0] RDATA, // read data
    output logic [1:0] RRESP, // read response
    output logic RVALID, // read data valid
    input wire logic RREADY, // read data ready
    output logic PS_STB, // present-state load pulse
    output sfc_ps_t PS_VAL, // present-state load values
    output sfc_ps_t PS_MASK, // present-state bits loaded
    output logic EVT_STB, // event load pulse
    output sfc_evt_t EVT_VAL, // event load values
    output sfc_evt_t EVT_MASK, // event bits loaded
    output logic INVALID_FLAG, // invalid supply request flag
    output logic RETEST, // reinterrogate card pulse
    output logic AUTO_POWER, // auto socket power control on
    output logic STOP_POLICY, // clock-stop policy bit
    output logic [2:0] VCC_REQ, // supply request field
    output logic [2:0] VPP_REQ, // programming request field
    output logic [2:0] VCC_APPLY, // supply actually applied
    output logic [2:0] VPP_APPLY, // programming applied
    output logic CLK_STOP_TRY // try to stop card clock
);

    logic aw_got;
    logic w_got;
    logic next_aw_got;
    logic next_w_got;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [31:0] bm;
    logic wr_fire;
    logic wf;
    logic wc;
    logic [3:0] caps;
    logic [3:0] idle_cnt;
    logic [3:0] next_idle;
    sfc_ps_t ps_word;
    sfc_ps_t ps_bits;
    sfc_evt_t evt_word;
    sfc_evt_t evt_bits;

    // aligned word hit, low address bits ignored
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] o);
        return a[ADDR_W-1:2] == (ADDR_W-2)'(o[7:2]);
    endfunction

    // voltage code the card accepts; reserved codes never do
    function automatic logic volt_ok(input logic [2:0] c,
                                     input logic [3:0] cap);
        logic r;
        r = 1'b0;
        case (c)
            SFC_V_OFF: r = 1'b1;
            SFC_V_12: r = 1'b1;
            SFC_V_5: r = cap[0];
            SFC_V_33: r = cap[1];
            SFC_V_XX: r = cap[2];
            SFC_V_YY: r = cap[3];
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // request invalid: reserved code or refused by the card
    function automatic logic bad_req(input logic [2:0] vcc,
                                     input logic [2:0] vpp,
                                     input logic cb,
                                     input logic [3:0] cap);
        logic r;
        r = (vcc == SFC_V_12) || (vcc > SFC_V_YY);
        r = r || (vpp > SFC_V_YY);
        r = r || (cb && !(volt_ok(vcc, cap) && volt_ok(vpp, cap)));
        return r;
    endfunction

    function automatic sfc_ps_t to_ps(input logic [31:0] d);
        return '{yy: d[SFC_F_YY], xx: d[SFC_F_XX],
                 three: d[SFC_F_THREE], five: d[SFC_F_FIVE],
                 loss: d[SFC_F_LOSS], unrec: d[SFC_F_UNREC],
                 cardbus: d[SFC_F_CARDBUS],
                 sixteen: d[SFC_F_SIXTEEN]};
    endfunction

    function automatic sfc_evt_t to_evt(input logic [31:0] d);
        return '{power: d[SFC_F_POWER], det_two: d[SFC_F_DET_TWO],
                 det_one: d[SFC_F_DET_ONE], status: d[SFC_F_STATUS]};
    endfunction

    // address and data may arrive in either order
    always_comb begin
        next_aw_got = aw_got;
        next_w_got = w_got;
        if (wr_fire) begin
            next_aw_got = 1'b0;
            next_w_got = 1'b0;
        end
        if (AWVALID && AWREADY) begin
            next_aw_got = 1'b1;
        end
        if (WVALID && WREADY) begin
            next_w_got = 1'b1;
        end
    end

    // byte strobes widened to a bit mask
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            bm[8*i +: 8] = {8{w_strb[i]}};
        end
    end

    // one write at a time; a new one waits for the response
    assign wr_fire = aw_got && w_got && !BVALID;
    assign wf = wr_fire && hit(aw_addr, SFC_FORCE_OFS);
    assign wc = wr_fire && hit(aw_addr, SFC_CTRL_OFS) && w_strb[0];
    assign caps = w_data[SFC_F_YY:SFC_F_FIVE] & bm[SFC_F_YY:SFC_F_FIVE];
    assign ps_word = to_ps(w_data);
    assign ps_bits = to_ps(bm);
    assign evt_word = to_evt(w_data);
    assign evt_bits = to_evt(bm);

    // write address and data capture
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            AWREADY <= 1'b0;
            WREADY <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (CE) begin
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            AWREADY <= !next_aw_got;
            WREADY <= !next_w_got;
            if (AWVALID && AWREADY) begin
                aw_addr <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_data <= WDATA;
                w_strb <= WSTRB;
            end
        end
    end

    // write response, error for an unmapped word
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            BVALID <= 1'b0;
            BRESP <= SFC_OKAY;
        end else if (CE) begin
            if (wr_fire) begin
                BVALID <= 1'b1;
                BRESP <= (hit(aw_addr, SFC_FORCE_OFS) ||
                          hit(aw_addr, SFC_CTRL_OFS)) ? SFC_OKAY : SFC_SLVERR;
            end else if (BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    // read channel; force bits are write-only and read zero
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ARREADY <= 1'b0;
            RVALID <= 1'b0;
            RDATA <= 32'h0000_0000;
            RRESP <= SFC_OKAY;
        end else if (CE) begin
            if (ARVALID && ARREADY) begin
                ARREADY <= 1'b0;
                RVALID <= 1'b1;
                RDATA <= 32'h0000_0000;
                RRESP <= SFC_OKAY;
                if (hit(ARADDR, SFC_CTRL_OFS)) begin
                    RDATA <= {24'h00_0000, STOP_POLICY, VCC_REQ,
                              1'b0, VPP_REQ};
                end else if (!hit(ARADDR, SFC_FORCE_OFS)) begin
                    RRESP <= SFC_SLVERR;
                end
            end else if (RVALID && RREADY) begin
                RVALID <= 1'b0;
                ARREADY <= 1'b1;
            end else if (!RVALID) begin
                ARREADY <= 1'b1;
            end
        end
    end

    // force loads, one pulse after the write is taken
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PS_STB <= 1'b0;
            PS_VAL <= '0;
            PS_MASK <= '0;
            EVT_STB <= 1'b0;
            EVT_VAL <= '0;
            EVT_MASK <= '0;
            RETEST <= 1'b0;
        end else if (CE) begin
            PS_STB <= wf;
            PS_VAL <= ps_word;
            PS_MASK <= wf ? ps_bits : '0;
            EVT_STB <= wf;
            EVT_VAL <= evt_word;
            EVT_MASK <= wf ? evt_bits : '0;
            RETEST <= wf && bm[SFC_F_RETEST] && w_data[SFC_F_RETEST];
        end
    end

    // retest in the same write wins, as software pairs them
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            AUTO_POWER <= 1'b1;
        end else if (CE) begin
            if (wf && bm[SFC_F_RETEST] && w_data[SFC_F_RETEST]) begin
                AUTO_POWER <= 1'b1;
            end else if (wf && (caps != 4'h0)) begin
                AUTO_POWER <= 1'b0;
            end
        end
    end

    // invalid flag: forced value, else judged on each request
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            INVALID_FLAG <= 1'b0;
        end else if (CE) begin
            if (wf && bm[SFC_F_INVALID]) begin
                INVALID_FLAG <= w_data[SFC_F_INVALID];
            end else if (wc) begin
                INVALID_FLAG <= bad_req(w_data[6:4], w_data[2:0],
                                        CARDBUS_IN, CARD_CAP);
            end
        end
    end

    // policy bit has no wake protection
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            STOP_POLICY <= SFC_POLICY_RESET;
        end else if (CE) begin
            if (HOST_BUS_RESET) begin
                STOP_POLICY <= SFC_POLICY_RESET;
            end else if (wc) begin
                STOP_POLICY <= w_data[SFC_C_POLICY];
            end
        end
    end

    // voltage requests survive host bus reset while wake is on
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            VCC_REQ <= SFC_VOLT_RESET;
            VPP_REQ <= SFC_VOLT_RESET;
        end else if (CE) begin
            if (HOST_BUS_RESET && !WAKE_EN) begin
                VCC_REQ <= SFC_VOLT_RESET;
                VPP_REQ <= SFC_VOLT_RESET;
            end else if (wc) begin
                VCC_REQ <= w_data[SFC_C_VCC +: 3];
                VPP_REQ <= w_data[SFC_C_VPP +: 3];
            end
        end
    end

    // screen against the card; screening is off under manual force
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            VCC_APPLY <= SFC_V_OFF;
            VPP_APPLY <= SFC_V_OFF;
        end else if (CE) begin
            VCC_APPLY <= VCC_REQ;
            VPP_APPLY <= VPP_REQ;
            if ((VCC_REQ == SFC_V_12) || (VCC_REQ > SFC_V_YY)) begin
                VCC_APPLY <= SFC_V_OFF;
            end else if (AUTO_POWER && CARDBUS_IN &&
                         !volt_ok(VCC_REQ, CARD_CAP)) begin
                VCC_APPLY <= SFC_V_OFF;
            end
            if (VPP_REQ > SFC_V_YY) begin
                VPP_APPLY <= SFC_V_OFF;
            end else if (AUTO_POWER && CARDBUS_IN &&
                         !volt_ok(VPP_REQ, CARD_CAP)) begin
                VPP_APPLY <= SFC_V_OFF;
            end
        end
    end

    // consecutive idle samples, saturating
    always_comb begin
        next_idle = 4'h0;
        if (CARD_IDLE) begin
            next_idle = (idle_cnt == SFC_IDLE_CLOCKS) ? idle_cnt : idle_cnt + 4'h1;
        end
    end

    // stop decision; host request only matters for policy zero
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            idle_cnt <= 4'h0;
            CLK_STOP_TRY <= 1'b0;
        end else if (CE) begin
            idle_cnt <= next_idle;
            CLK_STOP_TRY <= (next_idle == SFC_IDLE_CLOCKS) &&
                            (STOP_POLICY || HOST_STOP_REQ);
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST || !CE);

    sequence s_idle8;
        CARD_IDLE [*8];
    endsequence

    sequence s_retest_wr;
        wf && bm[SFC_F_RETEST] && w_data[SFC_F_RETEST];
    endsequence

    a_retest_pulse: assert property (s_retest_wr |=> RETEST && AUTO_POWER)
        else $error("retest did not pulse or restore auto power");
    a_force_manual: assert property (wf && caps != 4'h0 && !RETEST &&
        !(bm[SFC_F_RETEST] && w_data[SFC_F_RETEST]) |=> !AUTO_POWER && !RETEST)
        else $error("voltage force left auto power on");
    a_invalid_load: assert property (wf && bm[SFC_F_INVALID] |=>
        INVALID_FLAG == $past(w_data[SFC_F_INVALID]))
        else $error("invalid flag not loaded by force");
    a_state_copy: assert property (wf |=> PS_STB &&
        PS_VAL == $past(ps_word) && PS_MASK == $past(ps_bits) ##1 !PS_STB)
        else $error("present-state force not copied");
    a_event_copy: assert property (wf |=> EVT_STB &&
        EVT_VAL == $past(evt_word) && EVT_MASK == $past(evt_bits))
        else $error("event force not copied");
    a_force_reads: assert property (ARVALID && ARREADY &&
        hit(ARADDR, SFC_FORCE_OFS) |=> RVALID && RDATA == 32'h0000_0000)
        else $error("force register read not zero");
    a_ctrl_reserved: assert property (RVALID |->
        (RDATA & ~SFC_CTRL_MASK) == 32'h0000_0000)
        else $error("control reserved bits not zero");
    a_stop_host: assert property (!STOP_POLICY && !HOST_STOP_REQ |=>
        !CLK_STOP_TRY)
        else $error("clock stop tried without host request");
    a_stop_policy: assert property (STOP_POLICY [*8] ##0 s_idle8 |=>
        CLK_STOP_TRY)
        else $error("clock stop not tried after eight idle");
    a_stop_busy: assert property (!CARD_IDLE |=> !CLK_STOP_TRY)
        else $error("clock stop tried while busy");
    a_refuse_volt: assert property (AUTO_POWER && CARDBUS_IN &&
        !volt_ok(VCC_REQ, CARD_CAP) |=> VCC_APPLY == SFC_V_OFF)
        else $error("unaccepted supply voltage applied");
    a_wake_keeps: assert property (HOST_BUS_RESET && WAKE_EN && !wc |=>
        $stable(VCC_REQ) && $stable(VPP_REQ))
        else $error("requests lost on host reset with wake");
    a_bad_code: assert property (wc && w_data[6:4] == SFC_V_12 &&
        !(HOST_BUS_RESET && !WAKE_EN) |=> INVALID_FLAG && VCC_REQ == SFC_V_12 ##1
        VCC_APPLY == SFC_V_OFF)
        else $error("reserved supply code not flagged");

endmodule

// file: testbench/sfc_card_model.sv
// sfc_card_model: seated card and power switch side, plus the outside
// present-state and event bits that the force strobes load.
// assumes it shares clock and global reset with sfc_top.
`timescale 1ns/1ps
module sfc_card_model import sfc_pkg::*; (
    input wire logic clk, // host bus clock
    input wire logic rst, // global reset
    input wire logic insert_cb, // a cardbus card is seated
    input wire logic busy, // card interface active
    input wire logic ps_stb, // present-state load pulse
    input wire sfc_ps_t ps_val, // present-state values
    input wire sfc_ps_t ps_mask, // present-state bits loaded
    input wire logic evt_stb, // event load pulse
    input wire sfc_evt_t evt_val, // event values
    input wire sfc_evt_t evt_mask, // event bits loaded
    input wire logic retest, // reinterrogate pulse
    output logic cardbus_in, // card kind seen
    output logic [3:0] card_cap, // accepted voltages
    output logic card_idle, // no card traffic
    output sfc_ps_t ps, // held present-state bits
    output sfc_evt_t evt, // held event bits
    output logic [7:0] n_retest // interrogations asked
);
    // a seated cardbus card takes 5 V only, so 3.3 V must be refused
    assign cardbus_in = insert_cb;
    assign card_cap = insert_cb ? 4'h1 : 4'h0;
    assign card_idle = !busy;
    // masked loads keep unstrobed bits, so a lane slip shows up
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ps <= '0;
            evt <= '0;
            n_retest <= 8'h00;
        end else begin
            if (ps_stb) ps <= (ps & ~ps_mask) | (ps_val & ps_mask);
            if (evt_stb) evt <= (evt & ~evt_mask) | (evt_val & evt_mask);
            if (retest) n_retest <= n_retest + 8'h01;
        end
    end
endmodule

// file: testbench/tb_socket_force_and_power_control.sv
// tb_socket_force_and_power_control: self-checking bench for sfc_top.
// assumes sfc_pkg, sfc_top and sfc_card_model compiled before it.
`timescale 1ns/1ps
module tb_socket_force_and_power_control import sfc_pkg::*;;
    logic CLK = 1'b0, RST = 1'b1, HOST_BUS_RESET = 1'b0, WAKE_EN = 1'b0, HOST_STOP_REQ = 1'b0;
    logic CE = 1'b1;
    logic insert_cb = 1'b0, busy = 1'b1, AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
    logic ARVALID = 1'b0, RREADY = 1'b0;
    logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
    logic [31:0] WDATA = 32'h0000_0000;
    logic [3:0] WSTRB = 4'h0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, PS_STB, EVT_STB, INVALID_FLAG, RETEST;
    logic AUTO_POWER, STOP_POLICY, CLK_STOP_TRY, CARDBUS_IN, CARD_IDLE;
    logic [1:0] BRESP, RRESP, resp;
    logic [31:0] RDATA, rd_data;
    logic [2:0] VCC_REQ, VPP_REQ, VCC_APPLY, VPP_APPLY;
    logic [3:0] CARD_CAP;
    logic [7:0] n_retest;
    sfc_ps_t PS_VAL, PS_MASK, ps;
    sfc_evt_t EVT_VAL, EVT_MASK, evt;
    int failures = 0, n_compared = 0, cycles = 0;
    // free-running 100 MHz clock
    initial begin
        forever #5 CLK = ~CLK;
    end
    sfc_top i_dut (.CLK(CLK), .RST(RST), .CE(CE), .HOST_BUS_RESET(HOST_BUS_RESET),
        .WAKE_EN(WAKE_EN), .CARDBUS_IN(CARDBUS_IN), .CARD_CAP(CARD_CAP), .CARD_IDLE(CARD_IDLE),
        .HOST_STOP_REQ(HOST_STOP_REQ), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
        .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .PS_STB(PS_STB), .PS_VAL(PS_VAL), .PS_MASK(PS_MASK), .EVT_STB(EVT_STB),
        .EVT_VAL(EVT_VAL), .EVT_MASK(EVT_MASK), .INVALID_FLAG(INVALID_FLAG), .RETEST(RETEST),
        .AUTO_POWER(AUTO_POWER), .STOP_POLICY(STOP_POLICY), .VCC_REQ(VCC_REQ),
        .VPP_REQ(VPP_REQ), .VCC_APPLY(VCC_APPLY), .VPP_APPLY(VPP_APPLY),
        .CLK_STOP_TRY(CLK_STOP_TRY));
    sfc_card_model i_card (.clk(CLK), .rst(RST), .insert_cb(insert_cb), .busy(busy),
        .ps_stb(PS_STB), .ps_val(PS_VAL), .ps_mask(PS_MASK), .evt_stb(EVT_STB),
        .evt_val(EVT_VAL), .evt_mask(EVT_MASK), .retest(RETEST), .cardbus_in(CARDBUS_IN),
        .card_cap(CARD_CAP), .card_idle(CARD_IDLE), .ps(ps), .evt(evt), .n_retest(n_retest));
    task automatic complete_run;
        if (failures == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // a hung handshake ends the run here
    always @(posedge CLK) begin
        cycles++;
        if (cycles > 20000) begin
            failures++;
            complete_run();
        end
    end
    // one write; each channel drops at its own handshake, #1 lets effects land
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic done;
        done = 1'b0;
        @(posedge CLK);
        AWADDR <= a;
        WDATA <= d;
        WSTRB <= s;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        while (!done) begin
            @(posedge CLK);
            if (AWVALID && AWREADY === 1'b1) AWVALID <= 1'b0;
            if (WVALID && WREADY === 1'b1) WVALID <= 1'b0;
            if (BVALID === 1'b1) begin
                done = 1'b1;
                resp = BRESP;
                BREADY <= 1'b0;
            end
        end
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        logic done;
        done = 1'b0;
        @(posedge CLK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        while (!done) begin
            @(posedge CLK);
            if (ARVALID && ARREADY === 1'b1) ARVALID <= 1'b0;
            if (RVALID === 1'b1) begin
                done = 1'b1;
                rd_data = RDATA;
                resp = RRESP;
                RREADY <= 1'b0;
            end
        end
    endtask
    task automatic t_force;
        rd(SFC_FORCE_OFS);
        check("force reset read", rd_data, 32'h0000_0000);
        check("force read resp", resp, SFC_OKAY);
        rd(SFC_CTRL_OFS);
        check("ctrl reset read", rd_data, 32'h0000_0000);
        wr(SFC_FORCE_OFS, 32'h0000_3FBF, 4'h1);
        check("force write resp", resp, SFC_OKAY);
        check("ps low lane", ps, 8'h07);
        check("events", evt, 4'hF);
        check("auto power kept", AUTO_POWER, 1'b1);
        wr(SFC_FORCE_OFS, 32'h0000_3FBF, 4'hF);
        check("ps all", ps, 8'hFF);
        check("invalid set", INVALID_FLAG, 1'b1);
        check("auto power off", AUTO_POWER, 1'b0);
        wr(SFC_FORCE_OFS, 32'h0000_0000, 4'hF);
        check("ps cleared", ps, 8'h00);
        check("events cleared", evt, 4'h0);
        check("invalid clear", INVALID_FLAG, 1'b0);
        check("auto power held", AUTO_POWER, 1'b0);
        rd(SFC_FORCE_OFS);
        check("force readback", rd_data, 32'h0000_0000);
        wr(SFC_FORCE_OFS, 32'h0000_4000, 4'hF);
        check("retest count", n_retest, 8'h01);
        check("auto power back", AUTO_POWER, 1'b1);
        wr(SFC_FORCE_OFS, 32'h0000_4C00, 4'hF);
        check("retest with caps", AUTO_POWER, 1'b1);
        check("caps loaded", ps, 8'h30);
        check("retest count two", n_retest, 8'h02);
    endtask
    // every code on both fields, no card screening yet
    task automatic t_codes;
        logic [2:0] c;
        for (int v = 0; v < 8; v++) begin
            c = v[2:0];
            wr(SFC_CTRL_OFS, {25'h0, c, 1'b0, c}, 4'hF);
            @(posedge CLK);
            #1;
            check("supply request", VCC_REQ, c);
            check("supply applied", VCC_APPLY, (c == 3'h1 || c > 3'h5) ? 3'h0 : c);
            check("program applied", VPP_APPLY, (c > 3'h5) ? 3'h0 : c);
            if (c < 3'h6) check("invalid flag", INVALID_FLAG, c == 3'h1);
        end
        wr(SFC_CTRL_OFS, 32'hFFFF_FFFF, 4'hF);
        rd(SFC_CTRL_OFS);
        check("ctrl readback", rd_data, 32'h0000_00F7);
        insert_cb <= 1'b1;
        wr(SFC_CTRL_OFS, 32'h0000_0030, 4'hF);
        @(posedge CLK);
        #1;
        check("refused 3v3", VCC_APPLY, SFC_V_OFF);
        check("refused flag", INVALID_FLAG, 1'b1);
        wr(SFC_CTRL_OFS, 32'h0000_0020, 4'hF);
        @(posedge CLK);
        #1;
        check("accepted 5v", VCC_APPLY, SFC_V_5);
        check("accepted flag", INVALID_FLAG, 1'b0);
        insert_cb <= 1'b0;
    endtask
    // host bus reset with wake on, then off
    task automatic t_wake;
        wr(SFC_CTRL_OFS, 32'h0000_0023, 4'hF);
        for (int w = 1; w >= 0; w--) begin
            @(posedge CLK);
            WAKE_EN <= w[0];
            HOST_BUS_RESET <= 1'b1;
            @(posedge CLK);
            HOST_BUS_RESET <= 1'b0;
            @(posedge CLK);
            #1;
            check("supply after bus reset", VCC_REQ, w[0] ? 3'h2 : 3'h0);
            check("program after bus reset", VPP_REQ, w[0] ? 3'h3 : 3'h0);
        end
    endtask
    // idle for exactly seven then eight sampled clocks
    task automatic idle_try(input logic [31:0] ctrl, input logic host, input logic exp);
        wr(SFC_CTRL_OFS, ctrl, 4'hF);
        @(posedge CLK);
        HOST_STOP_REQ <= host;
        busy <= 1'b0;
        repeat (7) @(posedge CLK);
        #1;
        check("stop after seven", CLK_STOP_TRY, 1'b0);
        @(posedge CLK);
        #1;
        check("stop after eight", CLK_STOP_TRY, exp);
        @(posedge CLK);
        busy <= 1'b1;
        @(posedge CLK);
        #1;
        check("stop after busy", CLK_STOP_TRY, 1'b0);
    endtask
    task automatic t_misc;
        idle_try(32'h0000_0080, 1'b0, 1'b1);
        idle_try(32'h0000_0000, 1'b0, 1'b0);
        idle_try(32'h0000_0000, 1'b1, 1'b1);
        // clock enable low: idle clocks must not count toward a stop
        @(posedge CLK);
        CE <= 1'b0;
        busy <= 1'b0;
        repeat (10) @(posedge CLK);
        #1;
        check("frozen stop", CLK_STOP_TRY, 1'b0);
        @(posedge CLK);
        busy <= 1'b1;
        CE <= 1'b1;
        rd(8'h20);
        check("unmapped read resp", resp, SFC_SLVERR);
        check("unmapped read data", rd_data, 32'h0000_0000);
        wr(8'h20, 32'hFFFF_FFFF, 4'hF);
        check("unmapped write resp", resp, SFC_SLVERR);
        rd(SFC_CTRL_OFS);
        check("ctrl untouched", rd_data, 32'h0000_0000);
    endtask
    initial begin
        repeat (20) @(posedge CLK);
        RST <= 1'b0;
        repeat (2) @(posedge CLK);
        #1;
        check("auto power at reset", AUTO_POWER, 1'b1);
        t_force();
        t_codes();
        t_wake();
        t_misc();
        complete_run();
    end
endmodule
